// >>> if_cal_pkg.sv
// Purpose: shared constants for the if filter calibration sequencer pair
// Assumes: device register words carry their address in bits 3:0
// Notes: bit positions are those of the device register words
package if_cal_pkg;
  // device register addresses (low four bits of a register word)
  localparam logic [3:0] DEV_REG_MUX = 4'h0;
  localparam logic [3:0] DEV_REG_CAL = 4'h5;
  localparam logic [3:0] DEV_REG_TONE = 4'h6;
  // register 5 fields
  localparam int COARSE_START_BIT = 4;
  localparam int CAL_DIV_LSB = 5;
  localparam int CAL_DIV_W = 9;
  localparam int MANUAL_ADJ_LSB = 14;
  localparam int ADJ_W = 6;
  // register 6 fields
  localparam int FINE_EN_BIT = 4;
  localparam int LOWER_TONE_LSB = 5;
  localparam int UPPER_TONE_LSB = 13;
  localparam int TONE_W = 8;
  localparam int DWELL_LSB = 21;
  localparam int DWELL_W = 10;
  // register 0 field: status output select
  localparam int MUX_SEL_LSB = 29;
  localparam logic [2:0] MUX_SEL_CAL_DONE = 3'h1;
  localparam logic [2:0] MUX_SEL_CAL_BUSY = 3'h2;
  // calibration timing
  localparam int COARSE_TIME_US = 200;
  localparam int CAL_CLK_KHZ = 50;
  localparam int COARSE_TICKS = COARSE_TIME_US * CAL_CLK_KHZ / 1000;
  localparam int FINE_STEPS = 10;
  localparam int RSSI_W = 7;
  localparam int RB_W = 16;
  // controller register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG_DIV = 8'h04;
  localparam logic [7:0] OFS_CFG_TONE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h18;
  localparam int INT_W = 2;
  localparam int INT_CAL_DONE = 0;
  localparam int INT_RB_DONE = 1;
endpackage : if_cal_pkg

// >>> if_cal_link.sv
// Purpose: register and status link between controller and sequencer
// Assumes: one clock domain, controller drives register words
// Notes: parallel stand-in for the serial programming port
`timescale 1ns/1ps
interface if_cal_link;
  logic reg_wr;
  logic [31:0] reg_word;
  logic rb_req;
  logic rb_valid;
  logic [15:0] rb_data;
  logic status_mux_output;
  modport device (
    input reg_wr, reg_word, rb_req,
    output rb_valid, rb_data, status_mux_output
  );
  modport host (
    output reg_wr, reg_word, rb_req,
    input rb_valid, rb_data, status_mux_output
  );
endinterface : if_cal_link

// >>> if_filter_cal_sequencer.sv
// Purpose: on-chip if filter calibration sequencer (coarse then fine)
// Assumes: clk_sys stands for the crystal; rssi_level is a settled level
// Notes: coarse step is timed only, the analog trim acts on coarse_active
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module if_filter_cal_sequencer
  import if_cal_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link to the controller
  if_cal_link.device link,
  // analog side
  input wire logic [RSSI_W-1:0] rssi_level,
  output logic [ADJ_W-1:0] filter_centre_adjust,
  output logic [TONE_W-1:0] tone_divide,
  output logic tone_enable,
  output logic lna_detach,
  output logic coarse_active
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_COARSE = 3'b001,
    ST_TONE_LO = 3'b010,
    ST_TONE_HI = 3'b011,
    ST_ADJUST = 3'b100
  } seq_state_e;

  // saturating step of the centre code
  function automatic logic [ADJ_W-1:0] step_adj(
    input logic [ADJ_W-1:0] cur,
    input logic up
  );
    if (up) begin
      step_adj = (&cur) ? cur : cur + 1'b1;
    end else begin
      step_adj = (cur == '0) ? cur : cur - 1'b1;
    end
  endfunction : step_adj

  seq_state_e state;
  logic [31:0] reg_mux;
  logic [31:0] reg_cal;
  logic [31:0] reg_tone;
  logic [CAL_DIV_W-1:0] div_cnt;
  logic seq_tick;
  logic [DWELL_W-1:0] dwell_cnt;
  logic [3:0] step_cnt;
  logic [RSSI_W-1:0] rssi_lo;
  logic cal_done;
  logic [ADJ_W-1:0] fine_result;
  logic start;
  logic [CAL_DIV_W-1:0] cal_div;
  logic [DWELL_W-1:0] dwell;
  logic [DWELL_W-1:0] half_dwell;

  assign cal_div = reg_cal[CAL_DIV_LSB +: CAL_DIV_W];
  assign dwell = reg_tone[DWELL_LSB +: DWELL_W];
  assign half_dwell = (dwell >> 1) == '0 ? DWELL_W'(1) : dwell >> 1;
  assign start = link.reg_wr && state == ST_IDLE
    && link.reg_word[3:0] == DEV_REG_CAL
    && link.reg_word[COARSE_START_BIT];

  // register latches; words arriving mid-calibration are dropped
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_mux <= '0;
      reg_cal <= '0;
      reg_tone <= '0;
    end else if (link.reg_wr && state == ST_IDLE) begin
      case (link.reg_word[3:0])
        DEV_REG_MUX: reg_mux <= link.reg_word;
        DEV_REG_CAL: reg_cal <= link.reg_word;
        DEV_REG_TONE: reg_tone <= link.reg_word;
        default: ;
      endcase
    end
  end

  // calibration clock divider, one tick per divider count
  always_ff @(posedge clk_sys) begin
    if (!reset_n || state == ST_IDLE) begin
      div_cnt <= '0;
      seq_tick <= 1'b0;
    end else if (div_cnt + 1'b1 >= cal_div) begin
      div_cnt <= '0;
      seq_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      seq_tick <= 1'b0;
    end
  end

  // sequence control
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      dwell_cnt <= '0;
      step_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          dwell_cnt <= '0;
          step_cnt <= '0;
          if (start) begin
            state <= ST_COARSE;
          end
        end
        ST_COARSE: begin
          if (seq_tick) begin
            if (dwell_cnt == DWELL_W'(COARSE_TICKS - 1)) begin
              dwell_cnt <= '0;
              state <= reg_tone[FINE_EN_BIT] ? ST_TONE_LO : ST_IDLE;
            end else begin
              dwell_cnt <= dwell_cnt + 1'b1;
            end
          end
        end
        ST_TONE_LO, ST_TONE_HI: begin
          if (seq_tick) begin
            if (dwell_cnt + 1'b1 >= half_dwell) begin
              dwell_cnt <= '0;
              state <= (state == ST_TONE_LO) ? ST_TONE_HI : ST_ADJUST;
            end else begin
              dwell_cnt <= dwell_cnt + 1'b1;
            end
          end
        end
        ST_ADJUST: begin
          if (step_cnt == 4'(FINE_STEPS - 1)) begin
            state <= ST_IDLE;
          end else begin
            step_cnt <= step_cnt + 1'b1;
            state <= ST_TONE_LO;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // tone measurements and centre correction
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rssi_lo <= '0;
      filter_centre_adjust <= '0;
    end else if (start) begin
      filter_centre_adjust <= link.reg_word[MANUAL_ADJ_LSB +: ADJ_W];
    end else if (state == ST_TONE_LO && seq_tick
        && dwell_cnt + 1'b1 >= half_dwell) begin
      rssi_lo <= rssi_level;
    end else if (state == ST_TONE_HI && seq_tick
        && dwell_cnt + 1'b1 >= half_dwell && rssi_lo != rssi_level) begin
      // stronger lower tone means the centre sits low
      filter_centre_adjust <= step_adj(filter_centre_adjust,
        rssi_lo > rssi_level);
    end
  end

  // analog side controls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tone_enable <= 1'b0;
      tone_divide <= '0;
      lna_detach <= 1'b0;
      coarse_active <= 1'b0;
    end else begin
      coarse_active <= state == ST_COARSE;
      tone_enable <= state == ST_TONE_LO || state == ST_TONE_HI;
      lna_detach <= state == ST_TONE_LO || state == ST_TONE_HI
        || state == ST_ADJUST;
      tone_divide <= (state == ST_TONE_HI)
        ? reg_tone[UPPER_TONE_LSB +: TONE_W]
        : reg_tone[LOWER_TONE_LSB +: TONE_W];
    end
  end

  // completion flag and stored fine result
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cal_done <= 1'b0;
      fine_result <= '0;
    end else if (start) begin
      cal_done <= 1'b0;
    end else if (state == ST_ADJUST && step_cnt == 4'(FINE_STEPS - 1)) begin
      cal_done <= 1'b1;
      fine_result <= filter_centre_adjust;
    end else if (state == ST_COARSE && seq_tick && !reg_tone[FINE_EN_BIT]
        && dwell_cnt == DWELL_W'(COARSE_TICKS - 1)) begin
      cal_done <= 1'b1;
    end
  end

  // status output multiplexer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      link.status_mux_output <= 1'b0;
    end else begin
      case (reg_mux[MUX_SEL_LSB +: 3])
        MUX_SEL_CAL_DONE: link.status_mux_output <= cal_done;
        MUX_SEL_CAL_BUSY: link.status_mux_output <= state != ST_IDLE;
        default: link.status_mux_output <= 1'b0;
      endcase
    end
  end

  // readback of the fine result, answered one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      link.rb_valid <= 1'b0;
      link.rb_data <= '0;
    end else begin
      link.rb_valid <= link.rb_req;
      if (link.rb_req) begin
        link.rb_data <= {{(RB_W - ADJ_W){1'b0}}, fine_result};
      end
    end
  end

endmodule : if_filter_cal_sequencer

// >>> if_cal_controller.sv
// Purpose: host-side controller that programs and runs filter calibration
// Assumes: software reaches it over apb with 32-bit words
// Notes: no port access is made while the device calibrates
`timescale 1ns/1ps
module if_cal_controller
  import if_cal_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // link to the device
  if_cal_link.host link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WR_MUX = 3'b001,
    H_WR_TONE = 3'b010,
    H_WR_CAL = 3'b011,
    H_WAIT_LO = 3'b100,
    H_WAIT_HI = 3'b101,
    H_READ = 3'b110
  } host_state_e;

  host_state_e state;
  logic fine_en;
  logic [CAL_DIV_W-1:0] cal_div;
  logic [ADJ_W-1:0] manual_adj;
  logic [31:0] cfg_tone;
  logic [ADJ_W-1:0] fine_result;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_enable;
  logic [INT_W-1:0] int_set;
  logic wr_acc;
  logic start_req;
  logic mapped;

  assign wr_acc = psel && penable && pwrite;
  assign start_req = wr_acc && paddr == OFS_CTRL && pwdata[0];
  assign mapped = paddr == OFS_CTRL || paddr == OFS_CFG_DIV
    || paddr == OFS_CFG_TONE || paddr == OFS_STATUS
    || paddr == OFS_INT_STATUS || paddr == OFS_INT_CLEAR
    || paddr == OFS_INT_ENABLE;

  // configuration registers, frozen while a calibration runs except int_enable, which stays writable
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fine_en <= 1'b0;
      cal_div <= '0;
      manual_adj <= '0;
      cfg_tone <= '0;
      int_enable <= '0;
    end else if (wr_acc) begin
      if (paddr == OFS_INT_ENABLE) int_enable <= pwdata[INT_W-1:0];
      if (state == H_IDLE) begin
        if (paddr == OFS_CTRL) fine_en <= pwdata[1];
        if (paddr == OFS_CFG_DIV) begin
          cal_div <= pwdata[CAL_DIV_W-1:0];
          manual_adj <= pwdata[CAL_DIV_W +: ADJ_W];
        end
        if (paddr == OFS_CFG_TONE) cfg_tone <= pwdata;
      end
    end
  end

  // program the device, then wait on the completion output
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= H_IDLE;
      link.reg_wr <= 1'b0;
      link.reg_word <= '0;
      link.rb_req <= 1'b0;
    end else begin
      link.reg_wr <= 1'b0;
      link.rb_req <= 1'b0;
      case (state)
        H_IDLE: if (start_req) state <= H_WR_MUX;
        H_WR_MUX: begin
          link.reg_wr <= 1'b1;
          link.reg_word <= {MUX_SEL_CAL_DONE, 25'h0, DEV_REG_MUX};
          state <= H_WR_TONE;
        end
        H_WR_TONE: begin
          link.reg_wr <= 1'b1;
          // dwell sits in bits 25:16 of the tone configuration word
          link.reg_word <= {1'b0, cfg_tone[16 +: DWELL_W],
            cfg_tone[15:8], cfg_tone[7:0], fine_en, DEV_REG_TONE};
          state <= H_WR_CAL;
        end
        H_WR_CAL: begin
          link.reg_wr <= 1'b1;
          link.reg_word <= {12'h000, manual_adj, cal_div, 1'b1,
            DEV_REG_CAL};
          state <= H_WAIT_LO;
        end
        H_WAIT_LO: if (!link.status_mux_output) state <= H_WAIT_HI;
        H_WAIT_HI: begin
          if (link.status_mux_output) begin
            link.rb_req <= fine_en;
            state <= fine_en ? H_READ : H_IDLE;
          end
        end
        H_READ: if (link.rb_valid) state <= H_IDLE;
        default: state <= H_IDLE;
      endcase
    end
  end

  // fine result capture
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fine_result <= '0;
    end else if (state == H_READ && link.rb_valid) begin
      fine_result <= link.rb_data[ADJ_W-1:0];
    end
  end

  // sticky interrupt flags, set wins over clear
  always_comb begin
    int_set = '0;
    int_set[INT_CAL_DONE] = state == H_WAIT_HI && link.status_mux_output;
    int_set[INT_RB_DONE] = state == H_READ && link.rb_valid;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      int_status <= '0;
    end else if (wr_acc && paddr == OFS_INT_CLEAR) begin
      int_status <= (int_status & ~pwdata[INT_W-1:0]) | int_set;
    end else begin
      int_status <= int_status | int_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // apb answer, no wait state: data and ready in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CTRL: prdata <= {30'h0, fine_en, 1'b0};
          OFS_CFG_DIV: prdata <= {17'h0, manual_adj, cal_div};
          OFS_CFG_TONE: prdata <= cfg_tone;
          OFS_STATUS: prdata <= {24'h0, fine_result,
            link.status_mux_output, state != H_IDLE};
          OFS_INT_STATUS: prdata <= {30'h0, int_status};
          OFS_INT_ENABLE: prdata <= {30'h0, int_enable};
          default: prdata <= '0;
        endcase
      end
    end
  end

endmodule : if_cal_controller

// >>> if_cal_properties.sv
// Purpose: link properties of the calibration pair
// Assumes: the controller always selects the completion signal
// Notes: sees the link signals only
`timescale 1ns/1ps
module if_cal_properties
  import if_cal_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link signals
  input wire logic reg_wr,
  input wire logic [31:0] reg_word,
  input wire logic rb_req,
  input wire logic rb_valid,
  input wire logic [15:0] rb_data,
  input wire logic status_mux_output
);
  logic start_word;
  logic mux_word;
  logic cal_run;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // decode of the words that matter
  assign start_word = reg_wr && reg_word[3:0] == DEV_REG_CAL &&
    reg_word[COARSE_START_BIT];
  assign mux_word = reg_wr && reg_word[3:0] == DEV_REG_MUX;
  // calibration in flight, from start word to completion edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cal_run <= 1'b0;
    end else if (start_word) begin
      cal_run <= 1'b1;
    end else if ($rose(status_mux_output)) begin
      cal_run <= 1'b0;
    end
  end
  a_start_drops_done: assert property (
    start_word |-> ##2 (!status_mux_output)[*8])
    else $error("completion did not drop at start");
  a_done_in_time: assert property (
    start_word |-> ##[3:1000] status_mux_output)
    else $error("calibration never completed");
  a_done_holds: assert property (
    status_mux_output && !start_word && !$past(start_word)
    |=> status_mux_output)
    else $error("completion dropped without a start");
  a_quiet_while_busy: assert property (
    cal_run |-> !reg_wr && !rb_req)
    else $error("link used during calibration");
  a_mux_selects_done: assert property (
    mux_word |-> reg_word[MUX_SEL_LSB+:3] == MUX_SEL_CAL_DONE)
    else $error("status select not completion");
  a_word_order: assert property (
    mux_word |=> reg_wr && reg_word[3:0] == DEV_REG_TONE ##1 start_word)
    else $error("register words out of order");
  a_rb_next_cycle: assert property (
    rb_req |=> rb_valid)
    else $error("readback answer late");
  a_rb_caused: assert property (
    rb_valid |-> $past(rb_req) && rb_data[15:6] == 10'h000)
    else $error("stray or malformed readback");
endmodule : if_cal_properties

// >>> if_filter_cal_sequencer_tb_top.sv
// Purpose: self-checking bench for controller and sequencer
// Assumes: small divider and dwell keep runs short
// Notes: rssi follows the tone divide in use
`timescale 1ns/1ps
module if_filter_cal_sequencer_tb_top
  import if_cal_pkg::*;
;
  typedef struct {
    logic fine;
    logic [5:0] manual;
    logic [6:0] rlo;
    logic [6:0] rhi;
    logic [5:0] exp;
  } row_s;
  localparam logic [8:0] DIV = 9'h002;
  localparam logic [9:0] DWELL = 10'h004;
  localparam logic [7:0] TONE_LO = 8'h21;
  localparam logic [7:0] TONE_HI = 8'h17;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [6:0] rssi_level, rlo, rhi;
  logic [5:0] filter_centre_adjust;
  logic [7:0] tone_divide;
  logic tone_enable, lna_detach, coarse_active, rerr, lna_was;
  logic seen_lo, seen_hi, tone_bad;
  int coarse_cyc, lna_rise, failures, n_checks;
  row_s rows [6] = '{'{1'b0, 6'h05, 7'h00, 7'h00, 6'h05},
    '{1'b1, 6'h14, 7'h28, 7'h1e, 6'h1e}, '{1'b1, 6'h14, 7'h1e, 7'h28, 6'h0a},
    '{1'b1, 6'h14, 7'h21, 7'h21, 6'h14}, '{1'b1, 6'h3a, 7'h28, 7'h1e, 6'h3f},
    '{1'b1, 6'h04, 7'h1e, 7'h28, 6'h00}};
  if_cal_link i_if_cal_link ();
  if_filter_cal_sequencer i_if_filter_cal_sequencer (.clk_sys(clk_sys),
    .reset_n(reset_n), .link(i_if_cal_link), .rssi_level(rssi_level),
    .filter_centre_adjust(filter_centre_adjust), .tone_divide(tone_divide),
    .tone_enable(tone_enable), .lna_detach(lna_detach),
    .coarse_active(coarse_active));
  if_cal_controller i_if_cal_controller (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(i_if_cal_link));
  if_cal_properties i_if_cal_properties (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_wr(i_if_cal_link.reg_wr),
    .reg_word(i_if_cal_link.reg_word), .rb_req(i_if_cal_link.rb_req),
    .rb_valid(i_if_cal_link.rb_valid), .rb_data(i_if_cal_link.rb_data),
    .status_mux_output(i_if_cal_link.status_mux_output));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // rssi source and analog-side monitors
  always @(posedge clk_sys) begin
    rssi_level <= (tone_divide === TONE_HI) ? rhi : rlo;
    if (coarse_active === 1'b1) coarse_cyc++;
    if (lna_detach === 1'b1 && lna_was !== 1'b1) lna_rise++;
    lna_was <= lna_detach;
    if (tone_enable === 1'b1 && tone_divide === TONE_LO) seen_lo = 1'b1;
    if (tone_enable === 1'b1 && tone_divide === TONE_HI) seen_hi = 1'b1;
    if (tone_enable === 1'b1 && lna_detach !== 1'b1) tone_bad = 1'b1;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wait_int(input logic [1:0] need);
    int n;
    n = 0;
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    while ((rdat[1:0] & need) !== need && n < 100) begin
      apb(1'b0, OFS_INT_STATUS, 32'h0);
      n++;
    end
    if (n >= 100) begin
      failures++;
      summarize();
    end
  endtask : wait_int
  task automatic start_cal(input logic fine, input logic [5:0] man);
    apb(1'b1, OFS_CFG_DIV, {17'h0, man, DIV});
    apb(1'b1, OFS_CFG_TONE, {6'h00, DWELL, TONE_HI, TONE_LO});
    apb(1'b1, OFS_CTRL, {30'h0, fine, 1'b1});
  endtask : start_cal
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic run_row(input row_s r);
    rlo = r.rlo;
    rhi = r.rhi;
    coarse_cyc = 0;
    lna_rise = 0;
    {seen_lo, seen_hi, tone_bad} = 3'h0;
    start_cal(r.fine, r.manual);
    wait_int({r.fine, 1'b1});
    // the registered divider tick adds one cycle on entry to coarse
    chk(coarse_cyc == COARSE_TICKS * DIV + 1, "coarse length");
    chk(filter_centre_adjust === r.exp, "centre code");
    chk(lna_rise == int'(r.fine), "lna detach");
    chk(seen_lo === r.fine && seen_hi === r.fine, "tones");
    chk(tone_bad === 1'b0, "lna during tone");
    chk(i_if_cal_link.status_mux_output === 1'b1, "done level");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat[1:0] === 2'h2 && rerr === 1'b0, "status word");
    chk(!r.fine || rdat[7:2] === r.exp, "fine result");
    chk(irq === 1'b1, "irq raised");
    apb(1'b1, OFS_INT_CLEAR, 32'h3);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk(rdat[0] === 1'b0 && irq === 1'b0, "irq cleared");
  endtask : run_row
  initial begin
    {reset_n, psel, penable, pwrite, lna_was} = 5'h00;
    {paddr, pwdata, rssi_level, rlo, rhi} = 61'h0;
    {failures, n_checks, coarse_cyc, lna_rise} = '0;
    {seen_lo, seen_hi, tone_bad} = 3'h0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    apb(1'b1, OFS_INT_ENABLE, 32'h1);
    foreach (rows[i]) run_row(rows[i]);
    // masked interrupt and writes refused while busy
    apb(1'b1, OFS_INT_ENABLE, 32'h0);
    start_cal(1'b1, 6'h14);
    apb(1'b1, OFS_CFG_DIV, 32'h00007e05);
    apb(1'b0, OFS_CFG_DIV, 32'h0);
    chk(rdat[14:0] === {6'h14, DIV}, "write while busy");
    wait_int(2'h3);
    chk(irq === 1'b0, "masked irq");
    apb(1'b1, OFS_INT_ENABLE, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(irq === 1'b1, "unmasked irq");
    // unmapped address
    apb(1'b0, 8'h1c, 32'h0);
    chk(rerr === 1'b1 && rdat === 32'h0, "unmapped access");
    // reset in mid calibration
    start_cal(1'b1, 6'h14);
    repeat (30) @(posedge clk_sys);
    do_reset();
    @(posedge clk_sys);
    chk({lna_detach, coarse_active, tone_enable, irq} === 4'h0, "reset out");
    chk(i_if_cal_link.status_mux_output === 1'b0, "reset status");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat === 32'h0, "reset status word");
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk(rdat === 32'h0, "reset int status");
    summarize();
  end
endmodule : if_filter_cal_sequencer_tb_top
